// [rtl/osc_select_reset_key_map.svh]
`ifndef OSC_SELECT_RESET_KEY_MAP_SVH
`define OSC_SELECT_RESET_KEY_MAP_SVH
`define ADDR_RESET_UNLOCK_KEY 16'h0a5c
`define ADDR_LOW_FREQ_OSC_TRIM 16'h0a6c
`define ADDR_HIGH_SPEED_OSC_CONFIG 16'h20bc
`define ADDR_SOFT_RESET_CONTROL 16'h0a60
`define ADDR_CLOCK_DIVIDER_CONFIG 16'h0a64
`define KEY_UNLOCK_VALUE 16'h12ea
`define HSOSC_RESET_VALUE 32'h0000_0034
`define HSOSC_RSVD_VALUE 32'h0000_0030
`define FREQ_SEL_BIT 2
`define SEL_RESET_VALUE 1'b1
`define TRIM_RESET_VALUE 16'h0088
`define TRIM_RSVD_RESET 12'h008
`define SOFT_RESET_WIDTH 16
`define HALVER_BIT 0
`endif

// [rtl/osc_select_reset_key_pkg.sv]
`default_nettype none
package osc_select_reset_key_pkg;
    typedef enum logic [1:0] {
        st_locked,
        st_unlocked
    } key_state_t;
endpackage : osc_select_reset_key_pkg
`default_nettype wire

// [rtl/key_lock_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface key_lock_if;
    logic wr_en;
    logic key_hit;
    logic ctrl_hit;
    logic unlocked;
    modport ctrl (output wr_en, output key_hit, output ctrl_hit,
        input unlocked);
    modport lock (input wr_en, input key_hit, input ctrl_hit,
        output unlocked);
endinterface : key_lock_if
`default_nettype wire

// [rtl/key_lock_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module key_lock_fsm (
    input wire logic i_clk,
    input wire logic i_rst,
    key_lock_if.lock kl
);
    osc_select_reset_key_pkg::key_state_t state_ff;
    osc_select_reset_key_pkg::key_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (kl.wr_en) begin
            if (kl.key_hit) begin
                nxt_state = osc_select_reset_key_pkg::st_unlocked;
            end else begin
                // control write consumes the key; others relock
                nxt_state = osc_select_reset_key_pkg::st_locked;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= osc_select_reset_key_pkg::st_locked;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign kl.unlocked = (state_ff == osc_select_reset_key_pkg::st_unlocked);

    property p_key_unlocks;
        @(posedge i_clk) disable iff (i_rst)
        (kl.wr_en && kl.key_hit) |=> kl.unlocked;
    endproperty
    a_key_unlocks: assert property (p_key_unlocks)
        else $error("key write did not unlock");

    property p_other_relocks;
        @(posedge i_clk) disable iff (i_rst)
        (kl.wr_en && !kl.key_hit) |=> !kl.unlocked;
    endproperty
    a_other_relocks: assert property (p_other_relocks)
        else $error("non-key write left protection unlocked");

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        !kl.wr_en |=> kl.unlocked == $past(kl.unlocked);
    endproperty
    a_hold: assert property (p_hold)
        else $error("lock state changed without a write");
endmodule : key_lock_fsm
`default_nettype wire

// [rtl/osc_select_reset_key_regs.sv]
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_reset_key_map.svh"
module osc_select_reset_key_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_osc_freq_select,
    output logic o_osc_is_32mhz,
    output logic o_sys_clock_halver,
    output logic o_sys_clock_fault,
    output logic [3:0] o_trim,
    output logic [15:0] o_soft_reset_control,
    output logic o_soft_reset_strobe
);
    logic sel_ff, nxt_sel;
    logic halver_ff, nxt_halver;
    logic [15:0] trim_ff, nxt_trim;
    logic [15:0] srst_ff, nxt_srst;
    logic strobe_ff, nxt_strobe;
    logic [31:0] rdata_ff, nxt_rdata;
    logic slverr_ff, nxt_slverr;
    logic access, wr, rd, hit;
    logic ack_ff, nxt_ack;
    logic [15:0] addr;
    key_lock_if kl();

    function automatic logic mapped(input logic [15:0] a);
        mapped = (a == `ADDR_RESET_UNLOCK_KEY) ||
            (a == `ADDR_LOW_FREQ_OSC_TRIM) ||
            (a == `ADDR_HIGH_SPEED_OSC_CONFIG) ||
            (a == `ADDR_SOFT_RESET_CONTROL) ||
            (a == `ADDR_CLOCK_DIVIDER_CONFIG);
    endfunction : mapped

    assign addr = i_paddr[15:0];
    assign access = i_psel && i_penable;
    // upper address bits must be clear for any register to answer
    assign hit = (i_paddr[31:16] == 16'h0000) && mapped(addr);
    // writes land only at the edge that completes the access
    assign wr = access && ack_ff && i_pwrite && hit;
    assign rd = access && !i_pwrite;

    assign kl.wr_en = wr;
    assign kl.key_hit = (addr == `ADDR_RESET_UNLOCK_KEY) &&
        (i_pwdata[15:0] == `KEY_UNLOCK_VALUE);
    assign kl.ctrl_hit = (addr == `ADDR_SOFT_RESET_CONTROL);

    key_lock_fsm u_lock (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .kl(kl)
    );

    always_comb begin
        nxt_sel = sel_ff;
        nxt_halver = halver_ff;
        nxt_trim = trim_ff;
        nxt_srst = srst_ff;
        nxt_ack = access && !ack_ff;
        nxt_strobe = 1'b0;
        nxt_rdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (access && !ack_ff && !hit) begin
            nxt_slverr = 1'b1;
        end
        if (wr) begin
            if (addr == `ADDR_HIGH_SPEED_OSC_CONFIG) begin
                nxt_sel = i_pwdata[`FREQ_SEL_BIT];
            end else if (addr == `ADDR_LOW_FREQ_OSC_TRIM) begin
                nxt_trim = i_pwdata[15:0];
            end else if (addr == `ADDR_CLOCK_DIVIDER_CONFIG) begin
                nxt_halver = i_pwdata[`HALVER_BIT];
            end else if (addr == `ADDR_SOFT_RESET_CONTROL) begin
                if (kl.unlocked) begin
                    nxt_srst = i_pwdata[15:0];
                    nxt_strobe = 1'b1;
                end
            end
        end
        if (rd && hit && !ack_ff) begin
            if (addr == `ADDR_HIGH_SPEED_OSC_CONFIG) begin
                nxt_rdata = `HSOSC_RSVD_VALUE;
                nxt_rdata[`FREQ_SEL_BIT] = sel_ff;
            end else if (addr == `ADDR_LOW_FREQ_OSC_TRIM) begin
                nxt_rdata = {16'h0000, trim_ff};
            end else if (addr == `ADDR_CLOCK_DIVIDER_CONFIG) begin
                nxt_rdata[`HALVER_BIT] = halver_ff;
            end else if (addr == `ADDR_SOFT_RESET_CONTROL) begin
                nxt_rdata = {16'h0000, srst_ff};
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_ff <= `SEL_RESET_VALUE;
            ack_ff <= 1'b0;
            halver_ff <= 1'b0;
            trim_ff <= `TRIM_RESET_VALUE;
            srst_ff <= 16'h0000;
            strobe_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            ack_ff <= nxt_ack;
            halver_ff <= nxt_halver;
            trim_ff <= nxt_trim;
            srst_ff <= nxt_srst;
            strobe_ff <= nxt_strobe;
            rdata_ff <= nxt_rdata;
            slverr_ff <= nxt_slverr;
        end
    end

    // one wait state lets read data and error come from flip-flops
    assign o_pready = ack_ff;
    assign o_prdata = rdata_ff;
    assign o_pslverr = slverr_ff;
    assign o_osc_freq_select = sel_ff;
    assign o_osc_is_32mhz = !sel_ff;
    assign o_sys_clock_halver = halver_ff;
    // flags 32 MHz chosen while the system clock is not halved
    assign o_sys_clock_fault = !sel_ff && !halver_ff;
    assign o_trim = trim_ff[3:0];
    assign o_soft_reset_control = srst_ff;
    assign o_soft_reset_strobe = strobe_ff;

    property p_sel_reset;
        @(posedge i_clk) $fell(i_rst) |-> o_osc_freq_select;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("select bit not 1 after reset");

    property p_sel_write;
        @(posedge i_clk) disable iff (i_rst)
        (wr && addr == `ADDR_HIGH_SPEED_OSC_CONFIG)
            |=> o_osc_freq_select == $past(i_pwdata[`FREQ_SEL_BIT]);
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("select bit did not take written value");

    property p_32m;
        @(posedge i_clk) disable iff (i_rst)
        o_osc_is_32mhz == !o_osc_freq_select;
    endproperty
    a_32m: assert property (p_32m)
        else $error("32 MHz indication wrong");

    property p_key_reads_zero;
        @(posedge i_clk) disable iff (i_rst)
        (rd && o_pready && addr == `ADDR_RESET_UNLOCK_KEY) |->
            o_prdata == 32'h0000_0000;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)
        else $error("key register read not zero");

    property p_trim;
        @(posedge i_clk) disable iff (i_rst)
        (wr && addr == `ADDR_LOW_FREQ_OSC_TRIM)
            |=> o_trim == $past(i_pwdata[3:0]);
    endproperty
    a_trim: assert property (p_trim)
        else $error("trim output did not follow write");

    sequence s_unlock;
        wr && kl.key_hit;
    endsequence
    sequence s_ctrl_wr;
        wr && kl.ctrl_hit;
    endsequence
    property p_ctrl_after_key;
        @(posedge i_clk) disable iff (i_rst)
        s_unlock ##[3:5] s_ctrl_wr |=> o_soft_reset_strobe;
    endproperty
    a_ctrl_after_key: assert property (p_ctrl_after_key)
        else $error("unlocked control write ignored");

    property p_locked_ignored;
        @(posedge i_clk) disable iff (i_rst)
        (wr && kl.ctrl_hit && !kl.unlocked) |=> !o_soft_reset_strobe &&
            $stable(o_soft_reset_control);
    endproperty
    a_locked_ignored: assert property (p_locked_ignored)
        else $error("locked control write took effect");

    property p_fault;
        @(posedge i_clk) disable iff (i_rst)
        o_sys_clock_fault |-> !o_osc_freq_select && !o_sys_clock_halver;
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault flag wrong");

    property p_one_wait;
        @(posedge i_clk) disable iff (i_rst)
        (access && !o_pready) |=> o_pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("access not answered after one wait state");

    property p_err_unmapped;
        @(posedge i_clk) disable iff (i_rst)
        (access && o_pready) |-> o_pslverr == !hit;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error response does not match decode");

    property p_locked_after_reset;
        @(posedge i_clk) $fell(i_rst) |-> !kl.unlocked;
    endproperty
    a_locked_after_reset: assert property (p_locked_after_reset)
        else $error("protection not locked after reset");

    property p_strobe_pulse;
        @(posedge i_clk) disable iff (i_rst)
        o_soft_reset_strobe |=> !o_soft_reset_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("soft reset strobe longer than one cycle");
endmodule : osc_select_reset_key_regs
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "osc_select_reset_key_map.svh"
module tb_top;
    localparam logic [31:0] a_key = {16'h0000, `ADDR_RESET_UNLOCK_KEY};
    localparam logic [31:0] a_trim = {16'h0000, `ADDR_LOW_FREQ_OSC_TRIM};
    localparam logic [31:0] a_hs = {16'h0000, `ADDR_HIGH_SPEED_OSC_CONFIG};
    localparam logic [31:0] a_ctl = {16'h0000, `ADDR_SOFT_RESET_CONTROL};
    localparam logic [31:0] a_div = {16'h0000, `ADDR_CLOCK_DIVIDER_CONFIG};
    localparam logic [31:0] a_bad = 32'h0000_0a70;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [31:0] i_paddr = 32'h0000_0000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_sel, o_is32, o_halv, o_fault, o_stb;
    logic [3:0] o_trim;
    logic [15:0] o_ctl;
    int bad_count = 0;
    int checked = 0;
    int m_sel, m_halv, m_trim, m_ctl, m_unl, m_stb;
    int exp_q[$];
    logic [15:0] seed = 16'h0059;
    always #2.5 i_clk = ~i_clk;
    osc_select_reset_key_regs osc_select_reset_key_regs_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_osc_freq_select(o_sel),
        .o_osc_is_32mhz(o_is32), .o_sys_clock_halver(o_halv),
        .o_sys_clock_fault(o_fault), .o_trim(o_trim),
        .o_soft_reset_control(o_ctl), .o_soft_reset_strobe(o_stb));
    task test_done;
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task chk_outs;
        chk("select", {31'd0, o_sel}, m_sel);
        chk("is_32mhz", {31'd0, o_is32}, m_sel ^ 1);
        chk("halver", {31'd0, o_halv}, m_halv);
        chk("fault", {31'd0, o_fault}, (m_sel | m_halv) ^ 1);
        chk("trim", {28'd0, o_trim}, m_trim & 15);
        chk("control", {16'd0, o_ctl}, m_ctl);
        chk("strobe", {31'd0, o_stb}, m_stb);
    endtask : chk_outs
    task do_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        m_sel = 1;
        m_halv = 0;
        m_trim = 32'h0000_0088;
        m_ctl = 0;
        m_unl = 0;
        m_stb = 0;
        #1 chk_outs();
    endtask : do_reset
    task op(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err, rdy, mapped;
        int n;
        rdy = 1'b0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 16 && rdy !== 1'b1; n++) begin
            @(posedge i_clk);
            rdy = o_pready;
            rd = o_prdata;
            err = o_pslverr;
        end
        if (rdy !== 1'b1) begin
            bad_count++;
            test_done();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        mapped = a == a_key || a == a_trim || a == a_hs || a == a_ctl ||
            a == a_div;
        m_stb = 0;
        chk("slverr", {31'd0, err}, {31'd0, !mapped});
        if (w && mapped) begin
            if (a == a_ctl && m_unl == 1) begin
                m_ctl = d[15:0];
                m_stb = 1;
            end
            if (a == a_hs)
                m_sel = d[2];
            if (a == a_div)
                m_halv = d[0];
            if (a == a_trim)
                m_trim = d[15:0];
            m_unl = (a == a_key && d[15:0] == `KEY_UNLOCK_VALUE);
        end else if (!w) begin
            exp_q.push_back(a == a_trim ? m_trim : a == a_hs ?
                32'h0000_0030 | (m_sel << 2) : a == a_ctl ? m_ctl :
                a == a_div ? m_halv : 0);
            chk("read", rd, exp_q.pop_front());
        end
        #1 chk_outs();
    endtask : op
    initial begin
        do_reset();
        op(0, a_key, 0);
        op(0, a_trim, 0);
        op(0, a_hs, 0);
        op(0, a_bad, 0);
        op(0, 32'h0001_0a6c, 0);
        op(1, 32'h0001_0a6c, 32'h0000_ffff);
        op(1, a_ctl, 32'h0000_5a5a);
        op(1, a_key, 32'h0000_12ea);
        op(1, a_ctl, 32'h0000_a5a5);
        op(1, a_ctl, 32'h0000_1111);
        op(1, a_key, 32'h0000_12ea);
        op(1, a_trim, 32'h0000_0077);
        op(1, a_ctl, 32'h0000_2222);
        op(1, a_key, 32'h0000_12eb);
        op(1, a_ctl, 32'h0000_3333);
        op(1, a_key, 32'h0000_12ea);
        op(1, a_bad, 32'h0000_ffff);
        op(1, a_ctl, 32'h0000_4444);
        op(0, a_ctl, 0);
        op(1, a_div, 32'h0000_0001);
        op(0, a_div, 0);
        op(1, a_hs, 32'h0000_0030);
        op(1, a_hs, 32'h0000_0034);
        op(1, a_div, 32'h0000_0000);
        op(1, a_hs, 32'h0000_0030);
        op(1, a_hs, 32'h0000_0034);
        op(1, a_div, 32'h0000_0001);
        repeat (8) begin
            seed = lfsr(seed);
            op(1, a_trim, {16'h0000, seed});
            op(0, a_trim, 0);
            op(1, a_hs, {seed, seed});
            op(0, a_hs, 0);
            op(1, a_key, {16'h0000, seed});
        end
        op(1, a_key, 32'h0000_12ea);
        do_reset();
        op(1, a_ctl, 32'h0000_6666);
        op(0, a_hs, 0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
